/* shared/glss_pkg.sv */
// shared constants and carrier types of the gate level shifter sequencer
package glss_pkg;

  // sampling clock rate and drive pair dead time
  localparam int unsigned CORE_CLK_MHZ  = 25;
  localparam int unsigned DEAD_TIME_NS  = 200;
  localparam int unsigned DEAD_CYC      = (DEAD_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  DEAD_CYC_W    = 8'(DEAD_CYC);

  // phase channel indices (channel n sits at index n-1)
  localparam logic [2:0]  FWD_START_CH  = 3'h3;
  localparam logic [2:0]  REV_START_CH  = 3'h2;
  localparam logic [2:0]  LAST_CH       = 3'h5;
  localparam logic [2:0]  FIRST_CH      = 3'h0;

  // reset values
  localparam logic        EVEN_RESET    = 1'h1;
  localparam logic        DIR_RESET     = 1'h0;
  localparam logic [4:0]  SYNC_RESET    = 5'h00;

  // timing inputs from the panel controller
  typedef struct packed {
    logic shift_clock_in;
    logic shape_clock_in;
    logic frame_start_in;
    logic parity_toggle_in;
    logic direction_in;
  } glss_in_t;

  // gate driver controls
  typedef struct packed {
    logic [5:0] phase_clock_outs;
    logic [5:0] phase_shape_outs;
    logic       vertical_start_out;
    logic       reset_pulse_out;
    logic       forward_drive_out;
    logic       reverse_drive_out;
    logic       even_out;
    logic       odd_out;
  } glss_out_t;

  localparam glss_out_t OUT_RESET = '{
    phase_clock_outs:   6'h00,
    phase_shape_outs:   6'h00,
    vertical_start_out: 1'h0,
    reset_pulse_out:    1'h0,
    forward_drive_out:  1'h0,
    reverse_drive_out:  1'h0,
    even_out:           1'h1,
    odd_out:            1'h0
  };

endpackage : glss_pkg

/* design/glss_sequencer.sv */
// gate level shifter sequencer: timing inputs to eighteen gate driver controls
// Functional notes
// R01 - shift clock rise raises active phase
// R02 - six phases rotate, one per shift period
// R03 - shape clock rise starts controlled discharge
// R04 - shape clock fall drives active phase low
// R05 - vertical start follows frame start, shift low
// R06 - frame start with shift low clears counters
// R07 - reset pulse follows frame start, shift high
// R08 - forward: order 4,5,6,1,2,3 from 4
// R09 - reverse: order 3,2,1,6,5,4 from 3
// R10 - latch direction on each frame start rise
// R11 - drive pair from direction and latched bit
// R12 - dead time on drive pair direction change
// R13 - vertical start truth table, low when abnormal
// R14 - reset pulse truth table, low when abnormal
// R15 - even/odd start 1/0, swap on toggle rise
// R16 - even and odd low while toggle high
// R17 - toggle high at frame start rise: abnormal
// R18 - abnormal forces phases, starts low, even high
// R19 - leave abnormal at next clean frame start
// R20 - drive pair holds last latched state
// R21 - two-flop sync and edge detect inputs
`timescale 1ns/10ps

module glss_sequencer
  import glss_pkg::*;
(
  // clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_rstn,
  // timing inputs from the panel controller pins
  input  wire glss_in_t  i_timing,
  // gate driver controls
  output glss_out_t      o_gate
);

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  glss_in_t   lvl;
  glss_in_t   rise;
  glss_in_t   fall;

  logic [2:0] pos_q;
  logic       first_q;
  logic       seq_rev_q;
  logic [5:0] drive_q;
  logic [5:0] shape_q;
  logic       abn_q;
  logic       abn_d;
  logic       new_frame;
  logic       even_q;
  logic       dir_latch_q;
  logic       want_rev;
  logic       cur_rev_q;
  logic       dead_busy_q;
  logic [7:0] dead_cnt_q;
  logic [2:0] step_pos;
  glss_out_t  out_q;

  function automatic logic [2:0] next_ch(input logic [2:0] p, input logic rev);
    if (rev) begin
      next_ch = (p == FIRST_CH) ? LAST_CH : p - 3'h1;
    end else begin
      next_ch = (p == LAST_CH) ? FIRST_CH : p + 3'h1;
    end
  endfunction : next_ch

  // pins are asynchronous to the core clock; only sync2 feeds logic
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
      prev_q  <= SYNC_RESET;
    end else begin
      sync1_q <= i_timing; // R21
      sync2_q <= sync1_q; // R21
      prev_q  <= sync2_q; // R21
    end
  end

  assign lvl  = sync2_q;
  assign rise = sync2_q & ~prev_q; // R21
  assign fall = ~sync2_q & prev_q; // R21

  // abnormal state is decided only at frame start rises
  assign abn_d = rise.frame_start_in ? lvl.parity_toggle_in : abn_q; // R17 R19

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      abn_q <= 1'h0;
    end else begin
      abn_q <= abn_d; // R17 R19
    end
  end

  // a clean frame start restarts the phase rotation
  assign new_frame = rise.frame_start_in & ~lvl.shift_clock_in; // R06

  assign step_pos = first_q ? pos_q : next_ch(pos_q, seq_rev_q); // R02

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pos_q     <= FWD_START_CH;
      first_q   <= 1'h1;
      seq_rev_q <= DIR_RESET;
    end else if (new_frame) begin
      seq_rev_q <= lvl.direction_in;
      pos_q     <= lvl.direction_in ? REV_START_CH : FWD_START_CH; // R06 R08 R09
      first_q   <= 1'h1; // R06
    end else if (rise.shift_clock_in && !abn_d) begin
      pos_q     <= step_pos; // R02 R08 R09
      first_q   <= 1'h0;
    end
  end

  // per channel: drive high, then discharge, then low
  // channels may overlap, so each keeps its own stage bits
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      drive_q <= 6'h00;
      shape_q <= 6'h00;
    end else if (abn_d || new_frame) begin
      drive_q <= 6'h00; // R18 R06
      shape_q <= 6'h00;
    end else begin
      if (rise.shift_clock_in) begin
        drive_q[step_pos] <= 1'h1; // R01
        shape_q[step_pos] <= 1'h0;
      end
      if (rise.shape_clock_in && drive_q[pos_q]) begin
        drive_q[pos_q] <= 1'h0; // R03
        shape_q[pos_q] <= 1'h1; // R03
      end
      if (fall.shape_clock_in) begin
        drive_q[pos_q] <= 1'h0; // R04
        shape_q[pos_q] <= 1'h0; // R04
      end
    end
  end

  // even/odd state; toggle and abnormal entry both act on rises
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      even_q <= EVEN_RESET; // R15
    end else if (abn_d) begin
      even_q <= EVEN_RESET; // R18
    end else if (rise.parity_toggle_in) begin
      even_q <= ~even_q; // R15
    end
  end

  // direction latch keeps the pair valid when direction pin floats
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      dir_latch_q <= DIR_RESET;
    end else if (rise.frame_start_in) begin
      dir_latch_q <= lvl.direction_in; // R10
    end
  end

  // latched reverse only counts while no frame start rise clears it
  assign want_rev = lvl.direction_in | (dir_latch_q & ~rise.frame_start_in); // R11 R20

  // both low for the dead time, then the new side rises
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cur_rev_q   <= DIR_RESET;
      dead_busy_q <= 1'h1;
      dead_cnt_q  <= DEAD_CYC_W;
    end else if (want_rev != cur_rev_q) begin
      cur_rev_q   <= want_rev; // R12
      dead_busy_q <= 1'h1; // R12
      dead_cnt_q  <= DEAD_CYC_W; // R12
    end else if (dead_busy_q) begin
      if (dead_cnt_q <= 8'h01) begin
        dead_busy_q <= 1'h0;
        dead_cnt_q  <= 8'h00;
      end else begin
        dead_cnt_q  <= dead_cnt_q - 8'h01;
      end
    end
  end

  // every output is registered
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      out_q <= OUT_RESET;
    end else begin
      out_q.phase_clock_outs   <= abn_d ? 6'h00 : drive_q; // R18
      out_q.phase_shape_outs   <= abn_d ? 6'h00 : shape_q; // R18
      out_q.vertical_start_out <= ~abn_d & lvl.frame_start_in & ~lvl.shift_clock_in; // R05 R13
      out_q.reset_pulse_out    <= ~abn_d & lvl.frame_start_in & lvl.shift_clock_in; // R07 R14
      out_q.forward_drive_out  <= ~dead_busy_q & ~cur_rev_q & (want_rev == cur_rev_q); // R08 R11 R12
      out_q.reverse_drive_out  <= ~dead_busy_q & cur_rev_q & (want_rev == cur_rev_q); // R09 R11 R12
      out_q.even_out           <= abn_d | (~lvl.parity_toggle_in & even_q); // R16 R18
      out_q.odd_out            <= ~abn_d & ~lvl.parity_toggle_in & ~even_q; // R16 R18
    end
  end

  assign o_gate = out_q;

endmodule : glss_sequencer

/* bench/glss_properties.sv */
// port checker for the gate level shifter sequencer
`timescale 1ns/10ps
module glss_properties
  import glss_pkg::*;
(
  input wire logic      i_core_clk,
  input wire logic      i_rstn,
  input wire glss_in_t  i_timing,
  input wire glss_out_t o_gate
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // level outputs lag the pins by three sampling edges, phase stages by four
  sequence pair_quiet;
    (!o_gate.forward_drive_out && !o_gate.reverse_drive_out)[*4];
  endsequence
  sequence shift_rose;
    $past(i_timing.shift_clock_in, 4) && !$past(i_timing.shift_clock_in, 5);
  endsequence
  vstart_cause_a: assert property (o_gate.vertical_start_out |->
    $past(i_timing.frame_start_in && !i_timing.shift_clock_in, 3)) else $error("vstart without cause");
  rstp_cause_a: assert property (o_gate.reset_pulse_out |->
    $past(i_timing.frame_start_in && i_timing.shift_clock_in, 3)) else $error("reset pulse without cause");
  pair_excl_a: assert property (!(o_gate.forward_drive_out && o_gate.reverse_drive_out))
    else $error("drive pair both high");
  pair_dead_a: assert property ($fell(o_gate.forward_drive_out) || $fell(o_gate.reverse_drive_out)
    |-> pair_quiet) else $error("drive pair dead time short");
  odd_dead_a: assert property (o_gate.odd_out |-> !$past(i_timing.parity_toggle_in, 3))
    else $error("odd high during parity pulse");
  phase_rise_a: assert property (|(o_gate.phase_clock_outs & ~$past(o_gate.phase_clock_outs))
    |-> shift_rose) else $error("phase rose without shift rise");
  shape_rise_a: assert property (|(o_gate.phase_shape_outs & ~$past(o_gate.phase_shape_outs))
    |-> $past(i_timing.shape_clock_in, 4)) else $error("shaping without shape rise");
  drive_shape_a: assert property ((o_gate.phase_clock_outs & o_gate.phase_shape_outs) == 6'h00)
    else $error("channel in drive and shaping");
endmodule : glss_properties
bind glss_sequencer glss_properties glss_properties_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_timing(i_timing), .o_gate(o_gate));

/* bench/glss_tcon_model.sv */
// panel timing controller model driving the sequencer timing pins
`timescale 1ns/10ps
module glss_tcon_model
  import glss_pkg::*;
(
  input  wire logic i_core_clk,
  output glss_in_t  o_timing
);
  initial o_timing = '0;
  // six cycles a level, well over the two the pin sync needs; returns at a falling edge
  task automatic drive(input glss_in_t v);
    @(posedge i_core_clk);
    o_timing <= v;
    repeat (5) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : drive
  task automatic req_abn(input glss_in_t v);
    v.parity_toggle_in = 1'h1;
    drive(v);
    v.frame_start_in = 1'h1;
    drive(v);
  endtask : req_abn
endmodule : glss_tcon_model

/* bench/gate_level_shifter_sequencer_tb_top.sv */
// self-checking testbench of the gate level shifter sequencer
`timescale 1ns/10ps
module gate_level_shifter_sequencer_tb_top;
  import glss_pkg::*;
  logic      core_clk = 1'h0;
  logic      rstn     = 1'h0;
  glss_in_t  timing;
  glss_out_t gate;
  glss_in_t  tv;
  int        error_cnt = 0;
  int        checks    = 0;
  int        cyc       = 0;
  always #20 core_clk = ~core_clk;
  glss_sequencer glss_sequencer_i (.i_core_clk(core_clk), .i_rstn(rstn), .i_timing(timing), .o_gate(gate));
  glss_tcon_model glss_tcon_model_i (.i_core_clk(core_clk), .o_timing(timing));
  task automatic chk(input string nm, input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // seven steps so the rotation wraps past the last channel
  task automatic frame(input logic dir, input logic [2:0] first);
    logic [2:0] ch;
    ch = first;
    tv = '0;
    tv.direction_in = dir;
    glss_tcon_model_i.drive(tv);
    tv.frame_start_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("vstart", 6'(gate.vertical_start_out), 6'h01);
    tv.frame_start_in = 1'h0;
    glss_tcon_model_i.drive(tv);
    chk("vstart", 6'(gate.vertical_start_out), 6'h00);
    chk("pair", {4'h0, gate.forward_drive_out, gate.reverse_drive_out}, {4'h0, ~dir, dir});
    for (int k = 0; k < 7; k++) begin
      tv.shift_clock_in = 1'h1;
      glss_tcon_model_i.drive(tv);
      chk("clk", gate.phase_clock_outs, 6'h01 << ch);
      tv.shape_clock_in = 1'h1;
      glss_tcon_model_i.drive(tv);
      chk("shape", gate.phase_shape_outs, 6'h01 << ch);
      tv.shift_clock_in = 1'h0;
      glss_tcon_model_i.drive(tv);
      chk("shape", gate.phase_shape_outs, 6'h01 << ch);
      tv.shape_clock_in = 1'h0;
      glss_tcon_model_i.drive(tv);
      chk("low", gate.phase_clock_outs | gate.phase_shape_outs, 6'h00);
      if (dir) ch = (ch == FIRST_CH) ? LAST_CH : ch - 3'h1;
      else ch = (ch == LAST_CH) ? FIRST_CH : ch + 3'h1;
    end
  endtask : frame
  task automatic latch_hold();
    tv.direction_in = 1'h0;
    glss_tcon_model_i.drive(tv);
    chk("pair", {4'h0, gate.forward_drive_out, gate.reverse_drive_out}, 6'h01);
  endtask : latch_hold
  task automatic pulse_parity();
    tv = '0;
    tv.shift_clock_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    tv.frame_start_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("rstp", {4'h0, gate.reset_pulse_out, gate.vertical_start_out}, 6'h02);
    tv.frame_start_in = 1'h0;
    tv.parity_toggle_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("eo", {3'h0, gate.reset_pulse_out, gate.even_out, gate.odd_out}, 6'h00);
    tv.parity_toggle_in = 1'h0;
    glss_tcon_model_i.drive(tv);
    chk("eo", {4'h0, gate.even_out, gate.odd_out}, 6'h01);
  endtask : pulse_parity
  task automatic abnormal();
    tv = '0;
    glss_tcon_model_i.drive(tv);
    glss_tcon_model_i.req_abn(tv);
    chk("abn", {2'h0, gate.vertical_start_out, gate.reset_pulse_out, gate.even_out, gate.odd_out}, 6'h02);
    tv.shift_clock_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("abn", gate.phase_clock_outs, 6'h00);
    tv = '0;
    glss_tcon_model_i.drive(tv);
    tv.frame_start_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("vstart", 6'(gate.vertical_start_out), 6'h01);
    tv.frame_start_in = 1'h0;
    tv.shift_clock_in = 1'h1;
    glss_tcon_model_i.drive(tv);
    chk("clk", gate.phase_clock_outs, 6'h08);
  endtask : abnormal
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (8) @(negedge core_clk);
    chk("eo", {2'h0, gate.even_out, gate.odd_out, gate.forward_drive_out, gate.reverse_drive_out}, 6'h0A);
    frame(1'h0, FWD_START_CH);
    frame(1'h1, REV_START_CH);
    latch_hold();
    frame(1'h0, FWD_START_CH);
    pulse_parity();
    abnormal();
    close_out();
  end
  // the whole run needs about 640 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      close_out();
    end
  end
endmodule : gate_level_shifter_sequencer_tb_top
